// ---- include/dcbs_pkg.sv ----
`default_nettype none
// =============================================
// Shared constants for the break sequencer
package dcbs_pkg;
    localparam int unsigned WORD_W   = 18;
    localparam int unsigned INDEX_W  = 4;
    localparam int unsigned DEPTH    = 16;
    // Bus map, byte addresses
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_INDEX  = 5'h08;
    localparam logic [4:0] OFF_MEM    = 5'h0C;
    // Field positions
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned STAT_DONE_BIT = 0;
    // Reset values
    localparam logic        CTRL_EN_RST = 1'b0;
    localparam logic [1:0]  BK_RST      = 2'h0;
    // Break counter codes
    localparam logic [1:0]  BK_WORD  = 2'h2;
    localparam logic [1:0]  BK_ADDR  = 2'h3;
    localparam logic [1:0]  BK_DATA  = 2'h1;
    // Sync-hold delay: 400 us at 50 MHz
    localparam int unsigned HOLD_US      = 400;
    localparam int unsigned CLK_MHZ      = 50;
    localparam int unsigned HOLD_CYCLES  = HOLD_US * CLK_MHZ;
    localparam int unsigned HOLD_W       = 16;
    // Sequencer states, one-hot
    typedef enum logic [11:0] {
        ST_IDLE     = 12'h001,
        ST_ENTRY    = 12'h002,
        ST_CNT_ADD  = 12'h004,
        ST_CNT_MEM  = 12'h008,
        ST_MOVE     = 12'h010,
        ST_ADR_STEP = 12'h020,
        ST_ADR_MEM  = 12'h040,
        ST_ADR_LOAD = 12'h080,
        ST_XFER     = 12'h100,
        ST_XFER_END = 12'h200,
        ST_OUT_IDLE = 12'h400,
        ST_RESUME   = 12'h800
    } dcbs_state_e;
endpackage
`default_nettype wire

// ---- include/dcbs_mem_if.sv ----
`default_nettype none
// =============================================
// Core memory port between sequencer and store
interface dcbs_mem_if;
    import dcbs_pkg::*;
    logic [INDEX_W-1:0] index;
    logic [WORD_W-1:0]  wdata;
    logic               we;
    logic [WORD_W-1:0]  rdata;
    modport master (output index, output wdata, output we, input rdata);
    modport slave  (input index, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ---- hw/dcbs_core_mem.sv ----
`default_nettype none
// =============================================
// Flip-flop core memory, read by index
module dcbs_core_mem
    import dcbs_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    dcbs_mem_if.slave        mem
);
    typedef struct packed {
        logic [DEPTH-1:0][WORD_W-1:0] word;
    } dcbs_mem_s;

    dcbs_mem_s st_q;
    dcbs_mem_s st_d;

    // Write port; read is combinational
    always_comb begin
        st_d = st_q;
        if (mem.we) begin
            st_d.word[mem.index] = mem.wdata;
        end
    end

    assign mem.rdata = st_q.word[mem.index];

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // dcbs_core_mem
`default_nettype wire

// ---- hw/dcbs_adder.sv ----
`default_nettype none
// =============================================
// Adder with carry-in and zero detect
module dcbs_adder
    import dcbs_pkg::*;
(
    input  wire logic [WORD_W-1:0] operand_i,
    input  wire logic              carry_i,
    output logic [WORD_W-1:0]      sum_o,
    output logic                   zero_o
);
    // Wraps modulo word size, as the count does
    assign sum_o  = operand_i + {{(WORD_W-1){1'b0}}, carry_i};
    assign zero_o = (sum_o == '0);
endmodule // dcbs_adder
`default_nettype wire

// ---- hw/dcbs_sequencer.sv ----
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
// Summary of operation
// [R01] Sync pulse sets force select at count cycle
// [R02] Count location address plus one into arith
// [R03] Break counter goes to 10 in count word
// [R04] Count read, incremented, written back
// [R05] Count wrapping to zero sets block done
// [R06] Peripheral stops on block done
// [R07] Next word 14 unless increment mode
// [R08] Arith address moves to buffer and address
// [R09] Counter steps to 11 at address cycle
// [R10] Read request gives second phase pulse
// [R11] Peripheral drives data on second phase
// [R12] Write request clears channel sync
// [R13] Address increment unless inhibit asserted
// [R14] Address read, incremented, written back
// [R15] Input data latched into arith register
// [R16] Counter to 01, address enable cleared
// [R17] Input cycle discards readout, writes arith
// [R18] Resume word, or new entry if pending
// [R19] Back to back only if flag reraised
// [R20] Resume clears force select, counter 00
// [R21] Sync hold cleared 400 us later
// [R22] Count word held two periods
// [R23] Grant with request sets address enable
// [R24] Output adds idle cycle with fourth phase
// [R25] Counter resets to 00 on asynchronous clear, else synchronous
module dcbs_sequencer
    import dcbs_pkg::*;
#(
    parameter int unsigned HOLD_CNT = HOLD_CYCLES
)(
    input  wire logic               clock_i,
    input  wire logic               nrst_i,
    // Avalon-MM slave
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // Peripheral side
    input  wire logic               channel_request_i,
    input  wire logic [INDEX_W-1:0] channel_addr_i,
    input  wire logic               read_request_i,
    input  wire logic               write_request_i,
    input  wire logic               address_increment_inhibit_i,
    input  wire logic               memory_increment_mode_i,
    input  wire logic [WORD_W-1:0]  io_data_i,
    output logic [WORD_W-1:0]       io_data_o,
    output logic                    channel_grant_o,
    output logic                    address_enable_o,
    output logic                    force_select_o,
    output logic                    block_done_o,
    output logic                    second_phase_pulse_o,
    output logic                    fourth_phase_pulse_o,
    output logic                    program_interrupt_sync_block_o
);
    // =============================================
    // State
    typedef struct packed {
        dcbs_state_e         state;
        logic [1:0]          bk;
        logic                channel_sync_ff;
        logic                channel_sync_hold_ff;
        logic                address_enable_ff;
        logic                force_select_ff;
        logic                block_done_ff;
        logic                sense_gate_ff;
        logic                second_phase;
        logic                fourth_phase;
        logic                pending;
        logic                hold_run;
        logic [HOLD_W-1:0]   hold_cnt;
        logic [WORD_W-1:0]   arith;
        logic [WORD_W-1:0]   buffer;
        logic [INDEX_W-1:0]  maddr;
        logic [WORD_W-1:0]   data_out;
        logic                ctrl_en;
        logic [INDEX_W-1:0]  sw_index;
        logic                ack;
        logic [31:0]         rdata;
    } dcbs_seq_s;

    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CNT - 1);

    dcbs_seq_s st_q;
    dcbs_seq_s st_d;

    dcbs_mem_if mem ();

    logic [WORD_W-1:0] add_a;
    logic              add_ci;
    logic [WORD_W-1:0] add_sum;
    logic              add_zero;
    logic              bus_req;
    logic              bus_ok;
    logic              is_input;

    // =============================================
    // Shared parts
    dcbs_core_mem u_mem (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .mem     (mem.slave)
    );

    dcbs_adder u_add (
        .operand_i (add_a),
        .carry_i   (add_ci),
        .sum_o     (add_sum),
        .zero_o    (add_zero)
    );

    // =============================================
    // Bus handshake
    // Memory window acked only between breaks; its write lands one cycle later,
    // at index maddr in ST_ENTRY if a break starts in that idle cycle
    assign bus_req  = avs_read | avs_write;
    assign bus_ok   = (avs_address != OFF_MEM) || (st_q.state == ST_IDLE);
    assign avs_waitrequest = bus_req & ~st_q.ack;
    assign avs_readdata    = st_q.rdata;
    assign is_input        = read_request_i;

    // Adder operand: address word or memory readout
    always_comb begin
        add_a  = mem.rdata;
        add_ci = 1'b1;
        if (st_q.state == ST_CNT_ADD) begin
            add_a = st_q.buffer; // R02
        end
        if (st_q.state == ST_ADR_MEM) begin
            add_ci = ~address_increment_inhibit_i; // R13
        end
    end

    // =============================================
    // Sequencer and registers
    always_comb begin
        st_d = st_q;
        st_d.second_phase = 1'b0;
        st_d.fourth_phase = 1'b0;
        // Software owns the memory port only between breaks
        if (st_q.state == ST_IDLE) begin
            mem.index = st_q.sw_index;
        end else begin
            mem.index = st_q.maddr;
        end
        mem.wdata = st_q.buffer;
        mem.we    = 1'b0;

        // Sync hold release after the delay, counter low bit clear
        if (st_q.hold_run) begin
            st_d.hold_cnt = st_q.hold_cnt + HOLD_W'(1);
            if (st_q.hold_cnt == HOLD_LAST && !st_q.bk[0]) begin
                st_d.channel_sync_hold_ff = 1'b0; // R21
                st_d.hold_run = 1'b0;
            end
        end

        case (st_q.state)
            ST_IDLE: begin
                if (st_q.ctrl_en && channel_request_i) begin
                    st_d.channel_sync_ff      = 1'b1;
                    st_d.channel_sync_hold_ff = 1'b1;
                    st_d.hold_run             = 1'b0;
                    st_d.state                = ST_ENTRY;
                end
            end

            ST_ENTRY: begin
                // Grant is up by now; it opens the address enable
                if (st_q.channel_sync_ff) begin
                    st_d.address_enable_ff = 1'b1; // R23
                end
                // Entry word: channel address into buffer
                st_d.buffer = {{(WORD_W-INDEX_W){1'b0}}, channel_addr_i};
                st_d.maddr  = channel_addr_i;
                st_d.state  = ST_CNT_ADD;
            end

            ST_CNT_ADD: begin
                st_d.force_select_ff = 1'b1; // R01
                st_d.arith           = add_sum; // R02
                st_d.bk              = BK_WORD; // R03
                st_d.sense_gate_ff   = 1'b1;
                // No continue bit: word stays a second period
                st_d.state           = ST_CNT_MEM; // R22
            end

            ST_CNT_MEM: begin
                mem.wdata    = add_sum; // R04
                mem.we       = 1'b1;
                st_d.buffer  = add_sum;
                if (add_zero) begin
                    st_d.block_done_ff = 1'b1; // R05
                end
                if (memory_increment_mode_i) begin
                    st_d.state = ST_RESUME;
                end else if (!st_q.bk[0]) begin
                    st_d.state = ST_MOVE; // R07
                end
            end

            ST_MOVE: begin
                st_d.buffer = st_q.arith; // R08
                st_d.maddr  = st_q.arith[INDEX_W-1:0];
                st_d.state  = ST_ADR_STEP;
            end

            ST_ADR_STEP: begin
                st_d.bk = BK_ADDR; // R09
                if (read_request_i) begin
                    st_d.second_phase = 1'b1; // R10
                end
                if (write_request_i) begin
                    st_d.channel_sync_ff   = 1'b0; // R12
                end
                st_d.state = ST_ADR_MEM;
            end

            ST_ADR_MEM: begin
                mem.wdata   = add_sum; // R14
                mem.we      = 1'b1;
                st_d.buffer = add_sum;
                st_d.maddr  = add_sum[INDEX_W-1:0];
                st_d.state  = ST_ADR_LOAD;
            end

            ST_ADR_LOAD: begin
                // Output transfer gates zeros: bus disabled
                st_d.arith   = is_input ? io_data_i : '0; // R15
                // Flag seen at this clock allows a new break
                st_d.pending = channel_request_i; // R19
                st_d.state   = ST_XFER;
            end

            ST_XFER: begin
                st_d.bk                = BK_DATA; // R16
                st_d.address_enable_ff = 1'b0; // R16
                if (is_input) begin
                    st_d.sense_gate_ff = 1'b0; // R17
                    mem.wdata   = st_q.arith; // R17
                    mem.we      = 1'b1;
                    st_d.buffer = st_q.arith;
                end else begin
                    st_d.buffer   = mem.rdata;
                    st_d.data_out = mem.rdata;
                end
                st_d.state = ST_XFER_END;
            end

            ST_XFER_END: begin
                st_d.state = is_input ? ST_RESUME : ST_OUT_IDLE;
            end

            ST_OUT_IDLE: begin
                if (write_request_i) begin
                    st_d.fourth_phase = 1'b1; // R24
                end
                st_d.state = ST_RESUME;
            end

            ST_RESUME: begin
                if (st_q.pending && st_q.ctrl_en && channel_request_i) begin
                    st_d.channel_sync_ff   = 1'b1; // R18
                    st_d.pending           = 1'b0;
                    st_d.state             = ST_ENTRY;
                end else begin
                    st_d.force_select_ff = 1'b0; // R20
                    st_d.bk              = BK_RST; // R20
                    st_d.channel_sync_ff = 1'b0;
                    st_d.address_enable_ff = 1'b0;
                    st_d.pending         = 1'b0;
                    st_d.hold_run        = 1'b1;
                    st_d.hold_cnt        = '0;
                    st_d.state           = ST_IDLE; // R18
                end
            end
            default: begin
                st_d.state = ST_IDLE;
            end
        endcase

        // Bus slave: answer one cycle after the request
        st_d.ack = 1'b0;
        if (bus_req && !st_q.ack && bus_ok) begin
            st_d.ack = 1'b1;
            case (avs_address)
                OFF_CTRL:   st_d.rdata = {31'h0, st_q.ctrl_en};
                OFF_STATUS: st_d.rdata = {15'h0, st_q.state,
                                          st_q.bk, st_q.channel_sync_hold_ff,
                                          st_q.channel_sync_ff, st_q.block_done_ff};
                OFF_INDEX:  st_d.rdata = {28'h0, st_q.sw_index};
                OFF_MEM:    st_d.rdata = {14'h0, mem.rdata};
                default:    st_d.rdata = 32'h0;
            endcase
        end
        if (avs_write && st_q.ack) begin
            case (avs_address)
                OFF_CTRL: st_d.ctrl_en = avs_writedata[CTRL_EN_BIT];
                OFF_STATUS: begin
                    // A new overflow in this cycle wins over the clear
                    if (avs_writedata[STAT_DONE_BIT] && !(st_q.state == ST_CNT_MEM
                                                         && add_zero)) begin
                        st_d.block_done_ff = 1'b0;
                    end
                end
                OFF_INDEX: st_d.sw_index = avs_writedata[INDEX_W-1:0];
                OFF_MEM: begin
                    mem.wdata = avs_writedata[WORD_W-1:0];
                    mem.we    = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // All transitions on the clock except the asynchronous power clear, which gives counter 00
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q          <= '0; // R25
            st_q.state    <= ST_IDLE;
            st_q.bk       <= BK_RST; // R25
            st_q.ctrl_en  <= CTRL_EN_RST;
        end else begin
            st_q <= st_d; // R25
        end
    end

    // =============================================
    // Outputs, all from flip-flops
    assign io_data_o            = st_q.data_out;
    assign channel_grant_o      = st_q.channel_sync_ff;
    assign address_enable_o     = st_q.address_enable_ff;
    assign force_select_o       = st_q.force_select_ff;
    assign block_done_o         = st_q.block_done_ff; // R06
    assign second_phase_pulse_o = st_q.second_phase; // R11
    assign fourth_phase_pulse_o = st_q.fourth_phase;
    assign program_interrupt_sync_block_o = st_q.channel_sync_hold_ff;
endmodule // dcbs_sequencer
`default_nettype wire

// ---- tb/dcbs_chk.sv ----
`default_nettype none
// ==========================================
// Port checks on the break sequencer
module dcbs_chk #(
    parameter int unsigned HOLD_CNT = 8
)(
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic read_request_i,
    input  wire logic write_request_i,
    input  wire logic channel_grant_o,
    input  wire logic address_enable_o,
    input  wire logic force_select_o,
    input  wire logic block_done_o,
    input  wire logic second_phase_pulse_o,
    input  wire logic fourth_phase_pulse_o,
    input  wire logic program_interrupt_sync_block_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slack over the hold count covers the resume handshake
    localparam int HOLD_LIM = int'(HOLD_CNT) + 6;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    property p_p2_req;
        second_phase_pulse_o |-> read_request_i && force_select_o;
    endproperty
    a_p2_req: assert property (p_p2_req)
        else $error("phase two pulse without read request or selection");
    property p_p2_one;
        second_phase_pulse_o |=> !second_phase_pulse_o;
    endproperty
    a_p2_one: assert property (p_p2_one)
        else $error("phase two pulse longer than one cycle");
    property p_p4_out;
        fourth_phase_pulse_o |-> write_request_i && !read_request_i && !address_enable_o;
    endproperty
    a_p4_out: assert property (p_p4_out)
        else $error("phase four pulse outside an output idle cycle");
    property p_done_sel;
        $rose(block_done_o) |-> force_select_o;
    endproperty
    a_done_sel: assert property (p_done_sel)
        else $error("block done set outside a break");
    property p_ena_grant;
        $rose(address_enable_o) |-> $past(channel_grant_o);
    endproperty
    a_ena_grant: assert property (p_ena_grant)
        else $error("address enable set without grant");
    property p_grant_drop;
        second_phase_pulse_o |-> ##[0:1] !channel_grant_o;
    endproperty
    a_grant_drop: assert property (p_grant_drop)
        else $error("grant kept after address cycle with write request");
    property p_sel_fall;
        $fell(force_select_o) |-> !address_enable_o;
    endproperty
    a_sel_fall: assert property (p_sel_fall)
        else $error("selection released before address enable");
    property p_hold;
        $fell(force_select_o) |-> ##[1:HOLD_LIM] !program_interrupt_sync_block_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("sync hold not released after delay");
endmodule // dcbs_chk
`default_nettype wire

// ---- tb/dcbs_periph.sv ----
`default_nettype none
// ==========================================
// Peripheral: flag, requests, data register
module dcbs_periph
    import dcbs_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              nrst_i,
    input  wire logic              go_i,
    input  wire logic              in_mode_i,
    input  wire logic              again_i,
    input  wire logic [WORD_W-1:0] word_i,
    input  wire logic              force_select_o,
    input  wire logic              channel_grant_o,
    input  wire logic              block_done_o,
    input  wire logic              second_phase_pulse_o,
    output logic                   channel_request_i,
    output logic                   read_request_i,
    output logic                   write_request_i,
    output logic [WORD_W-1:0]      io_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold_q;
    // Flag and data lines; stale data is toggled every cycle once the two-cycle hold after the second phase runs out
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            channel_request_i <= 1'b0;
            read_request_i    <= 1'b0;
            write_request_i   <= 1'b0;
            io_data_i         <= '0;
            hold_q            <= 2'h0;
        end else begin
            read_request_i  <= force_select_o & in_mode_i;
            write_request_i <= force_select_o;
            if (go_i) begin
                channel_request_i <= 1'b1;
            end else if (second_phase_pulse_o && again_i && !block_done_o) begin
                channel_request_i <= 1'b1;
            end else if (channel_grant_o) begin
                channel_request_i <= 1'b0;
            end
            if (second_phase_pulse_o) begin
                io_data_i <= word_i;
                hold_q    <= 2'h2;
            end else if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end else begin
                io_data_i <= ~io_data_i;
            end
        end
    end
endmodule // dcbs_periph
`default_nettype wire

// ---- tb/data_channel_break_sequencer_test.sv ----
`default_nettype none
// ==========================================
// Bench with scoreboard queues
module data_channel_break_sequencer_test
    import dcbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HOLD_SIM = 8;
    typedef struct {string name; logic [31:0] exp;} dcbs_note_s;
    logic               clock_i = 1'b0;
    logic               nrst_i;
    logic [4:0]         avs_address;
    logic               avs_read, avs_write, avs_waitrequest;
    logic [31:0]        avs_writedata, avs_readdata;
    logic               channel_request_i, read_request_i, write_request_i;
    logic               inhibit, inc_mode, go, in_mode, again;
    logic [WORD_W-1:0]  io_data_i, io_data_o, word;
    logic               channel_grant_o, address_enable_o, force_select_o, block_done_o;
    logic               second_phase_pulse_o, fourth_phase_pulse_o, sync_blk;
    dcbs_note_s         rd_q[$];
    dcbs_note_s         out_q[$];
    int                 num_errors = 0;
    int                 samples_checked = 0;
    always #10 clock_i = ~clock_i;
    dcbs_sequencer #(.HOLD_CNT(HOLD_SIM)) u_dut (
        .clock_i, .nrst_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .channel_request_i, .channel_addr_i(4'h2),
        .read_request_i, .write_request_i, .address_increment_inhibit_i(inhibit),
        .memory_increment_mode_i(inc_mode), .io_data_i, .io_data_o, .channel_grant_o,
        .address_enable_o, .force_select_o, .block_done_o, .second_phase_pulse_o,
        .fourth_phase_pulse_o, .program_interrupt_sync_block_o(sync_blk));
    dcbs_periph u_per (
        .clock_i, .nrst_i, .go_i(go), .in_mode_i(in_mode), .again_i(again), .word_i(word),
        .force_select_o, .channel_grant_o, .block_done_o, .second_phase_pulse_o,
        .channel_request_i, .read_request_i, .write_request_i, .io_data_i);
    // ==========================================
    // Tasks
    task automatic conclude();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(ref dcbs_note_s q[$], input logic [31:0] v);
        dcbs_note_s n;
        samples_checked++;
        if (q.size() == 0) begin
            num_errors++;
            $display("[ERR] result expected none seen %h", v);
        end else begin
            n = q.pop_front();
            if (n.exp !== v) begin
                num_errors++;
                $display("[ERR] %s expected %h seen %h", n.name, n.exp, v);
            end
        end
    endtask
    // One bus cycle; a read notes its expectation first
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d, input string n);
        @(posedge clock_i);
        if (!wr) rd_q.push_back('{n, d});
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic mem(input logic wr, input logic [3:0] i, input logic [WORD_W-1:0] v);
        av(1'b1, OFF_INDEX, 32'(i), "");
        av(wr, OFF_MEM, 32'(v), "memory word");
    endtask
    // Raise the flag, wait for selection to end, then let sync hold expire
    task automatic run_break(input logic inm, input logic ag);
        int n;
        bit seen;
        @(posedge clock_i);
        in_mode <= inm;
        again   <= ag;
        go      <= 1'b1;
        @(posedge clock_i);
        go   <= 1'b0;
        seen = 0;
        for (n = 0; n < 400; n++) begin
            @(posedge clock_i);
            if (force_select_o === 1'b1) seen = 1;
            if (seen && force_select_o === 1'b0) break;
        end
        if (n == 400) begin
            num_errors++;
            $display("[ERR] break end expected 1 seen 0");
        end
        repeat (HOLD_SIM + 30) @(posedge clock_i);
    endtask
    // Scoreboard: read answers and output words
    always @(posedge clock_i) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(rd_q, avs_readdata);
        if (fourth_phase_pulse_o === 1'b1) check(out_q, 32'(io_data_o));
    end
    initial begin
        repeat (10000) @(posedge clock_i);
        num_errors++;
        $display("[ERR] run end expected done seen hang");
        conclude();
    end
    // ==========================================
    // Main sequence
    initial begin
        logic [WORD_W-1:0] c, a, d, loc;
        int k;
        nrst_i = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {inhibit, inc_mode, go, in_mode, again, word} = '0;
        void'($urandom(32'hA7AC));
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        av(1'b0, OFF_CTRL, 32'h0000_0000, "ctrl");
        av(1'b0, OFF_STATUS, 32'(ST_IDLE) << 5, "status");
        av(1'b1, 5'h10, 32'hFFFF_FFFF, "");
        av(1'b0, 5'h10, 32'h0000_0000, "unmapped");
        av(1'b1, OFF_CTRL, 32'h0000_0001, "");
        $display("test reset done");
        // Input, input with inhibit, output
        for (k = 0; k < 3; k++) begin
            c = 18'($urandom_range(1000, 1));
            a = {14'($urandom()), 4'h7};
            d = 18'($urandom());
            loc = (k == 1) ? a : a + 18'h1;
            inhibit <= (k == 1);
            word    <= d;
            mem(1'b1, 4'h2, c);
            mem(1'b1, 4'h3, a);
            if (k == 2) mem(1'b1, loc[3:0], d);
            if (k == 2) out_q.push_back('{"output word", 32'(d)});
            run_break(k != 2, 1'b0);
            mem(1'b0, 4'h2, c + 18'h1);
            mem(1'b0, 4'h3, loc);
            mem(1'b0, loc[3:0], d);
            av(1'b0, OFF_STATUS, 32'(ST_IDLE) << 5, "status");
            $display("test transfer %0d done", k);
        end
        // Back-to-back breaks, count wraps in the second
        c = 18'h3FFFE;
        inhibit <= 1'b0;
        mem(1'b1, 4'h2, c);
        mem(1'b1, 4'h3, a);
        run_break(1'b1, 1'b1);
        mem(1'b0, 4'h2, 18'h0);
        mem(1'b0, 4'h3, a + 18'h2);
        mem(1'b0, 4'h9, d);
        av(1'b0, OFF_STATUS, (32'(ST_IDLE) << 5) | 32'h1, "status");
        av(1'b1, OFF_STATUS, 32'h0000_0001, "");
        av(1'b0, OFF_STATUS, 32'(ST_IDLE) << 5, "status");
        $display("test back to back done");
        // Count-only break leaves address and data alone
        inc_mode <= 1'b1;
        word     <= ~d;
        mem(1'b1, 4'h2, 18'h3FFFF);
        run_break(1'b1, 1'b0);
        mem(1'b0, 4'h2, 18'h0);
        mem(1'b0, 4'h3, a + 18'h2);
        mem(1'b0, 4'h9, d);
        av(1'b0, OFF_STATUS, (32'(ST_IDLE) << 5) | 32'h1, "status");
        $display("test count only done");
        conclude();
    end
endmodule // data_channel_break_sequencer_test
bind dcbs_sequencer dcbs_chk #(.HOLD_CNT(HOLD_CNT)) u_chk (
    .clock_i, .nrst_i, .read_request_i, .write_request_i, .channel_grant_o, .address_enable_o,
    .force_select_o, .block_done_o, .second_phase_pulse_o, .fourth_phase_pulse_o,
    .program_interrupt_sync_block_o);
`default_nettype wire
